// *** core/iss_pkg.sv ***
/*
  Shared constants and types of the shutter and power-state sequencer:
  power states, user actions, shutter modes, configuration addresses,
  timing counts.
  Assumes a single 20 MHz clock shared by both ends.
*/
// Functional notes
// - Master trigger: a rising edge in idle starts frame
// - Master: exposure count, frame overhead, rows
// - Master: falling trigger edge changes nothing
// - Edges before exposure and overhead end dropped
// - One image per trigger, then idle
// - Pixel array held in reset until triggered
// - Slave: assert integrates, release starts overhead
// - Host asserts sync per frame, width exposes
// - Rolling: separate reset and read row pointers
// - Rolling: continuous stream, equal row exposure
// - Rolling: reset storage, sample, transfer, sample
// - Six power states, moved only by actions
// - Low power standby: clock-setup registers only
// - Standby one: synthesizer on, logic clock off
// - Standby two: logic clock, all registers
// - Idle: all blocks but sequencer enabled
// - Running: capture per selected shutter mode
// - Host waits 10 us after reset release
// - Host uploads clock settings in fixed order
// - Host keeps differential clock running serially without synthesizer
// - Parallel mode: reference clock, synthesizer bypassed
// - Host waits for lock before second step
package iss_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ      = 20000;
  localparam int WAIT_US      = 10;
  localparam int WAIT_CYC     = (WAIT_US * CLK_KHZ + 999) / 1000;
  localparam int ROWS         = 1200;
  localparam int RW           = 11;
  localparam int ROT_CYC      = 8;
  localparam int FOT_CYC      = 16;
  localparam int LOCK_CYC     = 64;
  localparam int TRIG_HI_CYC  = 4;

  localparam logic [RW-1:0] LAST_ROW = RW'(ROWS - 1);
  localparam logic [2:0]    ROT_LAST = 3'(ROT_CYC - 1);

  // Row phases inside one row overhead slot
  localparam logic [2:0] PH_A = 3'h1;
  localparam logic [2:0] PH_B = 3'h2;
  localparam logic [2:0] PH_C = 3'h3;
  localparam logic [2:0] PH_D = 3'h4;

  // ----------------------------------------------------------------
  // Configuration space
  // ----------------------------------------------------------------
  localparam logic [3:0] A_CLK_MODE = 4'h0;
  localparam logic [3:0] A_PLL_EN   = 4'h1;
  localparam logic [3:0] A_SHUT     = 4'h2;
  localparam logic [3:0] A_EXPO     = 4'h3;
  localparam int         MODE_PLL   = 0;
  localparam int         MODE_PAR   = 1;
  localparam logic [15:0] EXPO_RST  = 16'h0040;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    P_OFF  = 3'h0,
    P_LPS  = 3'h1,
    P_SB1  = 3'h2,
    P_SB2  = 3'h3,
    P_IDLE = 3'h4,
    P_RUN  = 3'h5
  } iss_pst_t;

  typedef enum logic [3:0] {
    ACT_PWR_ON  = 4'h0,
    ACT_CLK1    = 4'h1,
    ACT_CLK2    = 4'h2,
    ACT_BLK_ON  = 4'h3,
    ACT_SEQ_ON  = 4'h4,
    ACT_SEQ_OFF = 4'h5,
    ACT_BLK_OFF = 4'h6,
    ACT_CLK_OFF = 4'h7,
    ACT_SLEEP   = 4'h8,
    ACT_PWR_OFF = 4'h9
  } iss_act_t;

  typedef enum logic [1:0] {
    SH_TGM = 2'h0,
    SH_TGS = 2'h1,
    SH_RS  = 2'h2
  } iss_shut_t;

endpackage

// *** core/iss_if.sv ***
/*
  Link between the host controller and the sensor sequencer.
  Assumes both ends share one clock; all signals are levels or
  one-cycle pulses sampled on the rising edge.
*/
`timescale 1ns/100ps
interface iss_if;
  logic        sync;
  logic        act_valid;
  logic [3:0]  act;
  logic        cfg_we;
  logic [3:0]  cfg_addr;
  logic [15:0] cfg_data;
  logic        dclk_run;
  logic        pll_lock;
  logic [2:0]  pstate;

  modport dev (
    input  sync, act_valid, act, cfg_we, cfg_addr, cfg_data, dclk_run,
    output pll_lock, pstate
  );
  modport host (
    output sync, act_valid, act, cfg_we, cfg_addr, cfg_data, dclk_run,
    input  pll_lock, pstate
  );
endinterface

// *** core/iss_dev.sv ***
/*
  Sensor end: power-state ladder, clock enables, configuration
  store, triggered global and rolling shutter sequencer.
  Assumes the link inputs are synchronous to clk except sync.
*/
`timescale 1ns/100ps
module iss_dev (
  input  wire logic          clk,
  input  wire logic          resetn,
  iss_if.dev                 lnk,
  output logic               array_rst,
  output logic               frame_overhead_period,
  output logic [10:0]        row_sel,
  output logic [10:0]        rst_sel,
  output logic               rst_row,
  output logic               sn_rst,
  output logic               smp_rst,
  output logic               xfer,
  output logic               smp_sig,
  output logic               frame_done,
  output logic               synth_en,
  output logic               lclk_en,
  output logic               blk_en,
  output logic               seq_en,
  output logic               ref_clk_sel
);

  typedef enum logic [1:0] {
    E_IDLE = 2'h0,
    E_INT  = 2'h1,
    E_WAIT = 2'h2,
    E_FOT  = 2'h3
  } iss_exp_t;

  // Strobes {sn_rst, smp_rst, xfer, smp_sig} for a row phase
  function automatic logic [3:0] row_strb(logic roll, logic [2:0] ph);
    logic [3:0] s;
    s = 4'h0;
    if (roll) begin
      if (ph == iss_pkg::PH_A) s = 4'h8;
      if (ph == iss_pkg::PH_B) s = 4'h4;
      if (ph == iss_pkg::PH_C) s = 4'h2;
      if (ph == iss_pkg::PH_D) s = 4'h1;
    end else begin
      if (ph == iss_pkg::PH_A) s = 4'h1;
      if (ph == iss_pkg::PH_B) s = 4'h8;
      if (ph == iss_pkg::PH_C) s = 4'h4;
    end
    return s;
  endfunction

  // --------------------------------------------------------------
  // Trigger synchroniser and edge detect
  // --------------------------------------------------------------
  logic s1_q, s2_q, s3_q;
  wire  rise = s2_q & ~s3_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= lnk.sync;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // --------------------------------------------------------------
  // Power state ladder
  // --------------------------------------------------------------
  iss_pkg::iss_pst_t ps_q, ps_d;
  wire act_is_off = lnk.act == iss_pkg::ACT_PWR_OFF;

  always_comb begin
    ps_d = ps_q;
    if (lnk.act_valid) begin
      if (act_is_off) begin
        ps_d = iss_pkg::P_OFF;
      end else begin
        unique case (ps_q)
          iss_pkg::P_OFF: begin
            if (lnk.act == iss_pkg::ACT_PWR_ON) ps_d = iss_pkg::P_LPS;
          end
          iss_pkg::P_LPS: begin
            if (lnk.act == iss_pkg::ACT_CLK1) ps_d = iss_pkg::P_SB1;
          end
          iss_pkg::P_SB1: begin
            if (lnk.act == iss_pkg::ACT_CLK2) ps_d = iss_pkg::P_SB2;
            if (lnk.act == iss_pkg::ACT_SLEEP) ps_d = iss_pkg::P_LPS;
          end
          iss_pkg::P_SB2: begin
            if (lnk.act == iss_pkg::ACT_BLK_ON) ps_d = iss_pkg::P_IDLE;
            if (lnk.act == iss_pkg::ACT_CLK_OFF) ps_d = iss_pkg::P_SB1;
          end
          iss_pkg::P_IDLE: begin
            if (lnk.act == iss_pkg::ACT_SEQ_ON) ps_d = iss_pkg::P_RUN;
            if (lnk.act == iss_pkg::ACT_BLK_OFF) ps_d = iss_pkg::P_SB2;
          end
          iss_pkg::P_RUN: begin
            if (lnk.act == iss_pkg::ACT_SEQ_OFF) ps_d = iss_pkg::P_IDLE;
          end
          default: ps_d = iss_pkg::P_OFF;
        endcase
      end
    end
  end

  // --------------------------------------------------------------
  // Configuration store
  // --------------------------------------------------------------
  logic [1:0]  mode_q;
  logic        pll_on_q;
  logic [1:0]  shut_q;
  logic [15:0] expo_q;
  wire pwr_up  = ps_q != iss_pkg::P_OFF;
  wire full_rw = ps_q == iss_pkg::P_SB2 || ps_q == iss_pkg::P_IDLE;
  wire par     = mode_q[iss_pkg::MODE_PAR];
  wire use_pll = mode_q[iss_pkg::MODE_PLL] & ~par;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode_q   <= 2'h0;
      pll_on_q <= 1'b0;
      shut_q   <= iss_pkg::SH_TGM;
      expo_q   <= iss_pkg::EXPO_RST;
    end else if (lnk.cfg_we && pwr_up) begin
      // Clock setup reachable from low power standby on
      if (lnk.cfg_addr == iss_pkg::A_CLK_MODE) mode_q <= lnk.cfg_data[1:0];
      if (lnk.cfg_addr == iss_pkg::A_PLL_EN) pll_on_q <= lnk.cfg_data[0];
      if (full_rw && lnk.cfg_addr == iss_pkg::A_SHUT) shut_q <= lnk.cfg_data[1:0];
      if (full_rw && lnk.cfg_addr == iss_pkg::A_EXPO) expo_q <= lnk.cfg_data;
    end
  end

  // --------------------------------------------------------------
  // Clock management
  // --------------------------------------------------------------
  logic [6:0] lock_cnt_q;
  wire synth_on = ps_d != iss_pkg::P_OFF && ps_d != iss_pkg::P_LPS;
  wire lock_hit = lock_cnt_q == 7'(iss_pkg::LOCK_CYC);
  // Bypassed synthesizer locks at once; receiver needs its clock
  wire lock_d = synth_on & (par | (use_pll ? lock_hit : lnk.dclk_run));

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lock_cnt_q   <= 7'h00;
      ps_q         <= iss_pkg::P_OFF;
      lnk.pstate   <= iss_pkg::P_OFF;
      lnk.pll_lock <= 1'b0;
      synth_en     <= 1'b0;
      lclk_en      <= 1'b0;
      blk_en       <= 1'b0;
      seq_en       <= 1'b0;
      ref_clk_sel  <= 1'b0;
    end else begin
      if (!(synth_on && use_pll && pll_on_q)) lock_cnt_q <= 7'h00;
      else if (!lock_hit) lock_cnt_q <= lock_cnt_q + 7'h01;
      ps_q         <= ps_d;
      lnk.pstate   <= ps_d;
      lnk.pll_lock <= lock_d;
      synth_en     <= synth_on;
      lclk_en      <= ps_d >= iss_pkg::P_SB2;
      blk_en       <= ps_d >= iss_pkg::P_IDLE;
      seq_en       <= ps_d == iss_pkg::P_RUN;
      ref_clk_sel  <= par;
    end
  end

  // --------------------------------------------------------------
  // Global shutter exposure control
  // --------------------------------------------------------------
  wire run    = ps_q == iss_pkg::P_RUN;
  wire roll   = run && shut_q == iss_pkg::SH_RS;
  wire glob   = run && !roll;
  wire slave  = shut_q == iss_pkg::SH_TGS;
  iss_exp_t    e_q, e_d;
  logic [15:0] ecnt_q, ecnt_d;
  logic        rd_busy_q;
  logic        rd_go;
  wire int_end = slave ? !s2_q : ecnt_q <= 16'h0001;

  always_comb begin
    e_d    = e_q;
    ecnt_d = ecnt_q - 16'h0001;
    rd_go  = 1'b0;
    unique case (e_q)
      E_IDLE: begin
        // Only a rising edge leaves idle; a fall matters only to end slave integration
        if (rise) begin
          e_d    = E_INT;
          ecnt_d = expo_q;
        end
      end
      E_INT: begin
        if (int_end) begin
          e_d    = rd_busy_q ? E_WAIT : E_FOT;
          ecnt_d = 16'(iss_pkg::FOT_CYC);
        end
      end
      E_WAIT: begin
        // Storage still being read: pixel array held in reset
        ecnt_d = 16'(iss_pkg::FOT_CYC);
        if (!rd_busy_q) e_d = E_FOT;
      end
      E_FOT: begin
        if (ecnt_q == 16'h0001) begin
          e_d   = E_IDLE;
          rd_go = 1'b1;
        end
      end
    endcase
    // Outside global shutter running the exposure control is forced to idle here
    if (!glob) e_d = E_IDLE;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      e_q       <= E_IDLE;
      ecnt_q    <= 16'h0000;
      frame_overhead_period       <= 1'b0;
      array_rst <= 1'b1;
    end else begin
      e_q       <= e_d;
      ecnt_q    <= ecnt_d;
      frame_overhead_period       <= e_d == E_FOT;
      array_rst <= !roll && (e_d == E_IDLE || e_d == E_WAIT);
    end
  end

  // --------------------------------------------------------------
  // Readout engine: row pointers and sampling phases
  // --------------------------------------------------------------
  logic [2:0]  rot_q;
  wire row_end = rot_q == iss_pkg::ROT_LAST;
  wire last    = row_sel == iss_pkg::LAST_ROW;
  wire rs_last = rst_sel == iss_pkg::LAST_ROW;
  localparam int RW_W = iss_pkg::RW;
  wire [RW_W-1:0] expo_rows;
  assign expo_rows = expo_q >= 16'(iss_pkg::ROWS) ?
                     iss_pkg::LAST_ROW : expo_q[RW_W-1:0];
  wire [3:0] strb = row_strb(roll, rot_q);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_busy_q  <= 1'b0;
      rot_q      <= 3'h0;
      row_sel    <= 11'h000;
      rst_sel    <= 11'h000;
      frame_done <= 1'b0;
    end else begin
      frame_done <= rd_busy_q && row_end && last;
      if (!run) begin
        rd_busy_q <= 1'b0;
      end else if (rd_go || (roll && !rd_busy_q)) begin
        rd_busy_q <= 1'b1;
        rot_q     <= 3'h0;
        row_sel   <= 11'h000;
        rst_sel   <= expo_rows;
      end else if (rd_busy_q) begin
        rot_q <= row_end ? 3'h0 : rot_q + 3'h1;
        if (row_end) begin
          // Both pointers step together: equal exposure per row
          row_sel <= last ? 11'h000 : row_sel + 11'h001;
          rst_sel <= rs_last ? 11'h000 : rst_sel + 11'h001;
          if (last && !roll) rd_busy_q <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_row <= 1'b0;
      sn_rst  <= 1'b0;
      smp_rst <= 1'b0;
      xfer    <= 1'b0;
      smp_sig <= 1'b0;
    end else begin
      rst_row <= roll && rd_busy_q && rot_q == iss_pkg::PH_A;
      sn_rst  <= rd_busy_q && strb[3];
      smp_rst <= rd_busy_q && strb[2];
      xfer    <= rd_busy_q && strb[1];
      smp_sig <= rd_busy_q && strb[0];
    end
  end

endmodule

// *** core/iss_host.sv ***
/*
  Host end: power-up wait, ordered clock setup, lock polling,
  shutter setup and trigger generation on the sync line.
  Assumes its resetn release marks the sensor reset release.
*/
`timescale 1ns/100ps
module iss_host (
  input  wire logic        clk,
  input  wire logic        resetn,
  iss_if.host              lnk,
  input  wire logic        start,
  input  wire logic        use_pll,
  input  wire logic        par_mode,
  input  wire logic [1:0]  shut_mode,
  input  wire logic [15:0] expo,
  input  wire logic        trig_req,
  output logic             running
);

  typedef enum logic [3:0] {
    H_WAIT = 4'h0,
    H_ON   = 4'h1,
    H_MODE = 4'h2,
    H_PLL  = 4'h3,
    H_CLK1 = 4'h4,
    H_LOCK = 4'h5,
    H_CLK2 = 4'h6,
    H_SHUT = 4'h7,
    H_EXPO = 4'h8,
    H_BLK  = 4'h9,
    H_SEQ  = 4'ha,
    H_RUN  = 4'hb
  } iss_hst_t;

  iss_hst_t    h_q;
  logic [7:0]  wcnt_q;
  logic [15:0] scnt_q;
  wire pll = use_pll & ~par_mode;
  wire slv = shut_mode == iss_pkg::SH_TGS;

  // --------------------------------------------------------------
  // Setup sequence
  // --------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      h_q          <= H_WAIT;
      wcnt_q       <= 8'h00;
      lnk.act_valid <= 1'b0;
      lnk.act      <= iss_pkg::ACT_PWR_ON;
      lnk.cfg_we   <= 1'b0;
      lnk.cfg_addr <= 4'h0;
      lnk.cfg_data <= 16'h0000;
      lnk.dclk_run <= 1'b0;
    end else begin
      lnk.act_valid <= 1'b0;
      lnk.cfg_we    <= 1'b0;
      // Receiver clock kept alive whenever serial without synthesizer
      lnk.dclk_run  <= ~use_pll & ~par_mode;
      unique case (h_q)
        H_WAIT: begin
          if (wcnt_q != 8'(iss_pkg::WAIT_CYC)) wcnt_q <= wcnt_q + 8'h01;
          else if (start) h_q <= H_ON;
        end
        H_ON: begin
          lnk.act_valid <= 1'b1;
          lnk.act       <= iss_pkg::ACT_PWR_ON;
          h_q           <= H_MODE;
        end
        H_MODE: begin
          lnk.cfg_we   <= 1'b1;
          lnk.cfg_addr <= iss_pkg::A_CLK_MODE;
          lnk.cfg_data <= {14'h0000, par_mode, use_pll};
          h_q          <= pll ? H_PLL : H_CLK1;
        end
        H_PLL: begin
          lnk.cfg_we   <= 1'b1;
          lnk.cfg_addr <= iss_pkg::A_PLL_EN;
          lnk.cfg_data <= 16'h0001;
          h_q          <= H_CLK1;
        end
        H_CLK1: begin
          lnk.act_valid <= 1'b1;
          lnk.act       <= iss_pkg::ACT_CLK1;
          h_q           <= H_LOCK;
        end
        H_LOCK: begin
          if (!pll || lnk.pll_lock) h_q <= H_CLK2;
        end
        H_CLK2: begin
          lnk.act_valid <= 1'b1;
          lnk.act       <= iss_pkg::ACT_CLK2;
          h_q           <= H_SHUT;
        end
        H_SHUT: begin
          lnk.cfg_we   <= 1'b1;
          lnk.cfg_addr <= iss_pkg::A_SHUT;
          lnk.cfg_data <= {14'h0000, shut_mode};
          h_q          <= H_EXPO;
        end
        H_EXPO: begin
          lnk.cfg_we   <= 1'b1;
          lnk.cfg_addr <= iss_pkg::A_EXPO;
          lnk.cfg_data <= expo;
          h_q          <= H_BLK;
        end
        H_BLK: begin
          lnk.act_valid <= 1'b1;
          lnk.act       <= iss_pkg::ACT_BLK_ON;
          h_q           <= H_SEQ;
        end
        H_SEQ: begin
          lnk.act_valid <= 1'b1;
          lnk.act       <= iss_pkg::ACT_SEQ_ON;
          h_q           <= H_RUN;
        end
        H_RUN: h_q <= H_RUN;
        default: h_q <= H_WAIT;
      endcase
    end
  end

  // --------------------------------------------------------------
  // Trigger pulses: width is one cycle less than the exposure in slave fashion
  // --------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      scnt_q   <= 16'h0000;
      lnk.sync <= 1'b0;
      running  <= 1'b0;
    end else begin
      running <= lnk.pstate == iss_pkg::P_RUN;
      if (scnt_q != 16'h0000) begin
        scnt_q <= scnt_q - 16'h0001;
      end else if (running && trig_req && !lnk.sync) begin
        scnt_q <= slv ? expo : 16'(iss_pkg::TRIG_HI_CYC);
      end
      lnk.sync <= scnt_q != 16'h0000 && scnt_q != 16'h0001;
    end
  end

endmodule

// *** testbench/iss_asserts.sv ***
/*
  Link checker: power-state ladder and host duties on the shared link.
  Assumes one clock and resetn asynchronous, active low.
*/
`timescale 1ns/100ps
module iss_asserts (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        sync,
  input wire logic        act_valid,
  input wire logic [3:0]  act,
  input wire logic        cfg_we,
  input wire logic [3:0]  cfg_addr,
  input wire logic [15:0] cfg_data,
  input wire logic        dclk_run,
  input wire logic        pll_lock,
  input wire logic [2:0]  pstate
);
  // ----------------------------------------------------------------
  // Helper state
  // ----------------------------------------------------------------
  logic [7:0] wait_q;
  logic [1:0] mode_q;
  logic       mode_seen_q;
  wire        clk_wr = cfg_we && cfg_addr == iss_pkg::A_CLK_MODE;

  // Saturates so the wait check holds for the rest of the run
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wait_q      <= 8'h00;
      mode_q      <= 2'h0;
      mode_seen_q <= 1'b0;
    end else begin
      if (wait_q != 8'hff)
        wait_q <= wait_q + 8'h01;
      if (clk_wr) begin
        mode_q      <= cfg_data[1:0];
        mode_seen_q <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_hold;
    !act_valid |=> $stable(pstate);
  endproperty
  a_hold: assert property (p_hold) else $error("state moved");

  property p_pwr_on;
    act_valid && act == iss_pkg::ACT_PWR_ON && pstate == iss_pkg::P_OFF
      |=> pstate == iss_pkg::P_LPS;
  endproperty
  a_pwr_on: assert property (p_pwr_on) else $error("no standby");

  property p_clk1;
    act_valid && act == iss_pkg::ACT_CLK1 && pstate == iss_pkg::P_LPS
      |=> pstate == iss_pkg::P_SB1;
  endproperty
  a_clk1: assert property (p_clk1) else $error("no standby one");

  property p_clk2;
    act_valid && act == iss_pkg::ACT_CLK2 && pstate == iss_pkg::P_SB1
      |=> pstate == iss_pkg::P_SB2;
  endproperty
  a_clk2: assert property (p_clk2) else $error("no standby two");

  property p_blk_on;
    act_valid && act == iss_pkg::ACT_BLK_ON && pstate == iss_pkg::P_SB2
      |=> pstate == iss_pkg::P_IDLE;
  endproperty
  a_blk_on: assert property (p_blk_on) else $error("no idle");

  property p_seq_on;
    act_valid && act == iss_pkg::ACT_SEQ_ON && pstate == iss_pkg::P_IDLE
      |=> pstate == iss_pkg::P_RUN;
  endproperty
  a_seq_on: assert property (p_seq_on) else $error("no running");

  property p_wait;
    act_valid || cfg_we |-> wait_q >= 8'(iss_pkg::WAIT_CYC);
  endproperty
  a_wait: assert property (p_wait) else $error("early access");

  property p_order;
    act_valid && act == iss_pkg::ACT_CLK1 |-> mode_seen_q;
  endproperty
  a_order: assert property (p_order) else $error("clock setup skipped");

  property p_dclk;
    pstate == iss_pkg::P_SB1 && mode_q == 2'h0 |-> dclk_run;
  endproperty
  a_dclk: assert property (p_dclk) else $error("clock input idle");

  property p_lock;
    act_valid && act == iss_pkg::ACT_CLK2 |-> pll_lock;
  endproperty
  a_lock: assert property (p_lock) else $error("step before lock");

  // Lock and state leave the same next-state flop stage together
  property p_lps;
    pstate == iss_pkg::P_LPS |-> !pll_lock;
  endproperty
  a_lps: assert property (p_lps) else $error("standby clock");

  property p_sync;
    $rose(sync) |-> pstate == iss_pkg::P_RUN;
  endproperty
  a_sync: assert property (p_sync) else $error("early trigger");
endmodule

// *** testbench/iss_bench.sv ***
/*
  Bench: host and sensor ends joined by the link, driven at host inputs.
  Assumes one 20 MHz clock and an asynchronous active-low reset.
*/
`timescale 1ns/100ps
module iss_bench;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        start = 1'b0;
  logic        use_pll = 1'b0;
  logic        par_mode = 1'b0;
  logic [1:0]  shut_mode = 2'h0;
  logic [15:0] expo = 16'h0001;
  logic        trig_req = 1'b0;
  logic        running, array_rst, frame_overhead_period, rst_row, sn_rst, smp_rst, xfer;
  logic        smp_sig, frame_done, synth_en, lclk_en, blk_en, seq_en;
  logic        ref_clk_sel, sync_q, fot_q;
  logic [10:0] row_sel, rst_sel;
  int          fail_count = 0;
  int          total_checks = 0;
  int          cyc = 0, n_fot = 0, n_done = 0, n_hi = 0;
  int          t_sr1, t_sf, t_fr, t_dn, t_sn, t_rs, t_xf, t_ss, t_rr;
  int          e, n0, s1, h0, d0;

  always #25 clk = ~clk;

  iss_if iss_if_i ();
  iss_host iss_host_i (.clk(clk), .resetn(resetn), .lnk(iss_if_i),
    .start(start), .use_pll(use_pll), .par_mode(par_mode),
    .shut_mode(shut_mode), .expo(expo), .trig_req(trig_req),
    .running(running));
  iss_dev iss_dev_i (.clk(clk), .resetn(resetn), .lnk(iss_if_i),
    .array_rst(array_rst), .frame_overhead_period(frame_overhead_period), .row_sel(row_sel),
    .rst_sel(rst_sel), .rst_row(rst_row), .sn_rst(sn_rst),
    .smp_rst(smp_rst), .xfer(xfer), .smp_sig(smp_sig),
    .frame_done(frame_done), .synth_en(synth_en), .lclk_en(lclk_en),
    .blk_en(blk_en), .seq_en(seq_en), .ref_clk_sel(ref_clk_sel));
  iss_asserts iss_asserts_i (.clk(clk), .resetn(resetn),
    .sync(iss_if_i.sync), .act_valid(iss_if_i.act_valid),
    .act(iss_if_i.act), .cfg_we(iss_if_i.cfg_we),
    .cfg_addr(iss_if_i.cfg_addr), .cfg_data(iss_if_i.cfg_data),
    .dclk_run(iss_if_i.dclk_run), .pll_lock(iss_if_i.pll_lock),
    .pstate(iss_if_i.pstate));

  // ----------------------------------------------------------------
  // Event times, taken where outputs are settled
  // ----------------------------------------------------------------
  always @(negedge clk) begin
    cyc++;
    if (iss_if_i.sync && !sync_q) t_sr1 = cyc;
    if (!iss_if_i.sync && sync_q) t_sf = cyc;
    if (frame_overhead_period && !fot_q) begin
      t_fr = cyc;
      n_fot++;
    end
    if (frame_overhead_period) n_hi++;
    if (frame_done) begin
      t_dn = cyc;
      n_done++;
    end
    if (sn_rst) t_sn = cyc;
    if (smp_rst) t_rs = cyc;
    if (xfer) t_xf = cyc;
    if (smp_sig) t_ss = cyc;
    if (rst_row) t_rr = cyc;
    sync_q = iss_if_i.sync;
    fot_q = frame_overhead_period;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      @(negedge clk);
      #1;
    end
  endtask

  task automatic wait_for(ref int cnt, input int lim);
    int old;
    old = cnt;
    while (cnt == old && lim > 0) begin
      tick(1);
      lim--;
    end
    check(lim > 0, 1'b1);
  endtask

  task automatic trig();
    @(negedge clk);
    trig_req = 1'b1;
    @(negedge clk);
    trig_req = 1'b0;
  endtask

  // Second reset each time: shutter mode is only taken before running
  task automatic bring_up(input logic [1:0] sm, input int ex);
    @(negedge clk);
    resetn = 1'b0;
    start = 1'b0;
    shut_mode = sm;
    expo = 16'(ex);
    use_pll = 1'($urandom);
    par_mode = 1'($urandom);
    repeat (20) @(negedge clk);
    check(array_rst, 1'b1);
    check(iss_if_i.pstate, iss_pkg::P_OFF);
    resetn = 1'b1;
    start = 1'b1;
    for (int i = 0; i < 3000 && running !== 1'b1; i++) tick(1);
    check({synth_en, lclk_en, blk_en, seq_en}, 4'hf);
    check(iss_if_i.pstate, iss_pkg::P_RUN);
    check(running, 1'b1);
    check(ref_clk_sel, par_mode);
  endtask

  function automatic int exp_rst(input int r, input int x);
    return (r + (x > 1199 ? 1199 : x)) % 1200;
  endfunction

  initial begin
    repeat (90000) @(posedge clk);
    fail_count++;
    $display("unexpected t=%0t watchdog", $time);
    end_of_test();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'hcbb4));
    e = 20 + $urandom % 20;
    bring_up(iss_pkg::SH_TGM, e);
    tick(50);
    check(array_rst, 1'b1);
    n0 = n_fot;
    trig();
    tick(4);
    s1 = t_sr1;
    tick(6);
    trig();
    wait_for(n_fot, 200);
    check(t_fr - s1, 3 + e);
    h0 = n_hi;
    tick(30);
    check(n_hi - h0, iss_pkg::FOT_CYC - 1);
    check(n_fot - n0, 1);
    trig();
    wait_for(n_done, 12000);
    check(t_dn - t_fr >= 9612 && t_dn - t_fr <= 9640, 1'b1);
    check(t_sn - t_ss, 1);
    check(t_rs - t_sn, 1);
    wait_for(n_fot, 200);
    check(n_fot - n0, 2);
    wait_for(n_done, 12000);
    tick(100);
    check(array_rst, 1'b1);
    check(n_fot - n0, 2);

    e = 10 + $urandom % 20;
    bring_up(iss_pkg::SH_TGS, e);
    trig();
    tick(7);
    check(array_rst, 1'b0);
    wait_for(n_fot, 200);
    check(t_sf - t_sr1, e - 1);
    check(t_fr - t_sf >= 3 && t_fr - t_sf <= 5, 1'b1);
    wait_for(n_done, 12000);

    e = 1 + $urandom % 1500;
    bring_up(iss_pkg::SH_RS, e);
    tick(40);
    for (int k = 0; k < 8; k++) begin
      check(rst_sel, exp_rst(row_sel, e));
      tick(300 + k);
    end
    for (int k = 0; k < 20 && t_ss != cyc; k++) tick(1);
    check(t_rs - t_sn, 1);
    check(t_xf - t_rs, 1);
    check(t_ss - t_xf, 1);
    check(t_rr, t_sn);
    wait_for(n_done, 12000);
    d0 = t_dn;
    wait_for(n_done, 12000);
    check(t_dn - d0, 1200 * iss_pkg::ROT_CYC);
    end_of_test();
  end
endmodule
